//--- verilog/cgc_pkg.sv
// package: register map, field layout and reset values of the clock generator
package cgc_pkg;
    localparam int CGC_AW = 4;
    localparam logic [3:0] CGC_OFF_CTRL1 = 4'h0;
    localparam logic [3:0] CGC_OFF_CTRL2 = 4'h4;
    localparam logic [3:0] CGC_OFF_STAT1 = 4'h8;
    // control one fields
    localparam int C1_HIGH_GAIN = 7;
    localparam int C1_RANGE = 6;
    localparam int C1_REFSEL = 5;
    localparam int C1_MODE_LO = 3;
    localparam int C1_OSCKEEP = 2;
    localparam int C1_DETECT_OFF = 1;
    // control two fields
    localparam int C2_LOCK_RST_SEL = 7;
    localparam int C2_MULT_LO = 4;
    localparam int C2_CLK_RST_SEL = 3;
    localparam int C2_DIV_LO = 0;
    // status one fields
    localparam int S1_MODE_LO = 6;
    localparam int S1_REF_KIND = 5;
    localparam int S1_LOCK_LOST = 4;
    localparam int S1_LOCK = 3;
    localparam int S1_CLK_LOST = 2;
    localparam int S1_EXT_READY = 1;
    localparam int S1_IRQF = 0;
    localparam logic [7:0] CGC_CTRL1_RST = 8'h00;
    localparam logic [7:0] CGC_CTRL2_RST = 8'h00;
    // cycles an accepted factor write stays busy
    localparam int CGC_FACTOR_BUSY_CYC = 4;
    typedef enum logic [1:0] {
        CGC_MODE_SELF = 2'b00,
        CGC_MODE_LOOP_INT = 2'b01,
        CGC_MODE_BYPASS_EXT = 2'b10,
        CGC_MODE_LOOP_EXT = 2'b11
    } cgc_mode_e;
endpackage

//--- verilog/cgc_sync2.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module cgc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

//--- verilog/cgc_ctrl.sv
// clock generator control/status registers on an avalon-mm slave
// Functional notes
// - keep-in-stop clear: off in stop unless enable, mode 10 and crystal ref.
// - keep-in-stop set: oscillator runs in stop for mode 1x and crystal ref.
// - keep-in-stop ignored when high-gain and range are both one.
// - clock-loss detection runs while detect-off is zero, suspended when one.
// - lock loss asks interrupt, or reset if selected; only while sticky set.
// - multiplier code 000..111 gives 4,6,...,18.
// - divider code 000..111 gives 1,2,4,...,128.
// - factor writes dropped while an earlier factor write still settles.
// - clock loss asks interrupt if reset-select zero, reset if one.
// - status shows mode: 00 self, 01 loop int, 10 bypass, 11 loop ext.
// - mode status changes only after the written mode crossed domains.
// - reference status reads zero for external clock, one for crystal.
// - sticky lock-loss flag set on unexpected lock loss until cleared.
// - lock bit follows loop lock, forced zero in off, self and bypass modes.
// - sticky clock-loss flag set on clock loss until cleared.
// - ext_ref_ready one only when external reference stable and fast enough.
// - irq flag set while pending; cleared by reset or read-then-write-one.
// - a new interrupt during the clear sequence restarts it; flag stays set.
// - writing zero to the irq flag has no effect.
// - mode select picks self, loop int, bypass ext or loop ext.
// - bypass request waits until ext_ref_ready reads one.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cgc_ctrl
    import cgc_pkg::*;
#(
    parameter int BUSY_CYC = CGC_FACTOR_BUSY_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [cgc_pkg::CGC_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic stop_mode,
    input wire logic loop_enable,
    input wire logic loop_locked_pin,
    input wire logic loop_unlock_event_pin,
    input wire logic clock_lost_pin,
    input wire logic ext_ref_stable_pin,
    output logic osc_enable,
    output logic clock_loss_detect_en,
    output logic [4:0] loop_factor_n,
    output logic [7:0] output_divide_r,
    output logic [1:0] active_mode,
    output logic reference_kind,
    output logic clockgen_irq,
    output logic clockgen_reset_req
);

    // the busy counter is eight bits wide and must load a non-zero count
    if (BUSY_CYC < 1 || BUSY_CYC > 255) begin : g_busy_range
        $error("cgc_ctrl: BUSY_CYC out of range");
    end

    localparam logic [7:0] BUSY_LOAD = 8'(BUSY_CYC);

    function automatic logic is_loop_mode(input logic [1:0] m);
        is_loop_mode = m[0];
    endfunction

    function automatic logic addr_hit(
        input logic [CGC_AW-1:0] a,
        input logic [3:0] off
    );
        addr_hit = a == off;
    endfunction

    // register read mux; unmapped offsets read as zero
    function automatic logic [7:0] reg_view(
        input logic [CGC_AW-1:0] a,
        input logic [7:0] c1,
        input logic [7:0] c2,
        input logic [7:0] s1
    );
        if (addr_hit(a, CGC_OFF_CTRL1))
            reg_view = c1;
        else if (addr_hit(a, CGC_OFF_CTRL2))
            reg_view = c2;
        else if (addr_hit(a, CGC_OFF_STAT1))
            reg_view = s1;
        else
            reg_view = 8'h00;
    endfunction

    // pins are asynchronous; nothing reads them before the second flop
    logic [3:0] pin_s;
    logic locked_s;
    logic unlock_s;
    logic lost_s;
    logic ext_ready_s;

    cgc_sync2 #(.W(4)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({loop_locked_pin, loop_unlock_event_pin, clock_lost_pin,
            ext_ref_stable_pin}),
        .q(pin_s)
    );

    assign locked_s = pin_s[3];
    assign unlock_s = pin_s[2];
    assign lost_s = pin_s[1];
    assign ext_ready_s = pin_s[0];

    // bus: one wait cycle per access so reads see settled status
    logic ack_reg;
    logic acc;

    assign acc = (avs_read | avs_write) & ~ack_reg;
    assign avs_waitrequest = acc;

    always_ff @(posedge clk_sys) begin
        if (rst)
            ack_reg <= 1'b0;
        else
            ack_reg <= acc;
    end

    // a write or read takes effect in the cycle waitrequest is low
    logic wr_c1;
    logic wr_c2;
    logic wr_s1;
    logic rd_s1;

    assign wr_c1 = avs_write & ack_reg &
                   addr_hit(avs_address, CGC_OFF_CTRL1);
    assign wr_c2 = avs_write & ack_reg &
                   addr_hit(avs_address, CGC_OFF_CTRL2);
    assign wr_s1 = avs_write & ack_reg &
                   addr_hit(avs_address, CGC_OFF_STAT1);
    assign rd_s1 = avs_read & ack_reg &
                   addr_hit(avs_address, CGC_OFF_STAT1);

    // control one
    logic [7:0] ctrl1_reg;
    logic first_wr_reg;
    logic ext_allowed;
    logic [1:0] mode_req;

    // external modes stay locked out if the first write chose internal,
    // since the reference pins were never claimed
    assign ext_allowed = first_wr_reg | ctrl1_reg[C1_MODE_LO+1];

    always_ff @(posedge clk_sys) begin
        if (rst)
            first_wr_reg <= 1'b1;
        else if (wr_c1)
            first_wr_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl1_reg <= CGC_CTRL1_RST;
        end else if (wr_c1) begin
            // high gain, range and reference select are write-once
            if (first_wr_reg)
                ctrl1_reg[7:5] <= avs_writedata[7:5];
            if (ext_allowed || !avs_writedata[C1_MODE_LO+1])
                ctrl1_reg[C1_MODE_LO +: 2] <=
                    avs_writedata[C1_MODE_LO +: 2];
            ctrl1_reg[C1_OSCKEEP] <= avs_writedata[C1_OSCKEEP];
            ctrl1_reg[C1_DETECT_OFF] <= avs_writedata[C1_DETECT_OFF];
        end
    end

    assign mode_req = ctrl1_reg[C1_MODE_LO +: 2];

    // factor writes occupy the loop for BUSY_CYC cycles
    logic [7:0] ctrl2_reg;
    logic [7:0] busy_reg;
    logic factor_idle;

    assign factor_idle = busy_reg == 8'h00;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl2_reg <= CGC_CTRL2_RST;
        end else if (wr_c2) begin
            ctrl2_reg[C2_LOCK_RST_SEL] <= avs_writedata[C2_LOCK_RST_SEL];
            ctrl2_reg[C2_CLK_RST_SEL] <= avs_writedata[C2_CLK_RST_SEL];
            if (factor_idle) begin
                ctrl2_reg[C2_MULT_LO +: 3] <= avs_writedata[C2_MULT_LO +: 3];
                ctrl2_reg[C2_DIV_LO +: 3] <= avs_writedata[C2_DIV_LO +: 3];
            end
        end
    end

    // a dropped write does not stretch the busy time
    always_ff @(posedge clk_sys) begin
        if (rst)
            busy_reg <= 8'h00;
        else if (wr_c2 && factor_idle)
            busy_reg <= BUSY_LOAD;
        else if (!factor_idle)
            busy_reg <= busy_reg - 8'h01;
    end

    // applied factors follow the register once the write has settled
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            loop_factor_n <= 5'h04;
            output_divide_r <= 8'h01;
        end else if (busy_reg == 8'h01) begin
            loop_factor_n <= {1'b0, ctrl2_reg[6:4], 1'b0} + 5'h04;
            output_divide_r <= 8'h01 << ctrl2_reg[2:0];
        end
    end

    // mode crosses a staging flop before it is reported
    logic [1:0] mode_stage_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_stage_reg <= CGC_MODE_SELF;
            active_mode <= CGC_MODE_SELF;
        end else begin
            mode_stage_reg <= mode_req;
            if (mode_stage_reg != CGC_MODE_BYPASS_EXT || ext_ready_s)
                active_mode <= mode_stage_reg;
        end
    end

    assign reference_kind = ctrl1_reg[C1_REFSEL];

    // in stop the oscillator follows the selected mode, not the active one,
    // so a bypass request still waiting for the reference keeps it alive
    logic osc_keep_ign;
    logic osc_next;

    assign osc_keep_ign = ctrl1_reg[C1_HIGH_GAIN] &
                          ctrl1_reg[C1_RANGE];

    always_comb begin
        if (!stop_mode)
            osc_next = active_mode != CGC_MODE_SELF &&
                       active_mode != CGC_MODE_LOOP_INT;
        else if (ctrl1_reg[C1_OSCKEEP] && !osc_keep_ign)
            osc_next = mode_req[1] & reference_kind;
        else
            osc_next = loop_enable && mode_req == CGC_MODE_BYPASS_EXT &&
                       reference_kind;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            osc_enable <= 1'b0;
        else
            osc_enable <= osc_next;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            clock_loss_detect_en <= 1'b0;
        else
            clock_loss_detect_en <= ~ctrl1_reg[C1_DETECT_OFF];
    end

    // lock qualified by mode; unexpected loss is an unlock event or a locked-to-unlocked drop
    logic lock_bit;
    logic lock_prev_reg;
    logic lol_ev;
    logic loc_ev;

    assign lock_bit = locked_s & is_loop_mode(active_mode) & ~stop_mode;

    always_ff @(posedge clk_sys) begin
        if (rst)
            lock_prev_reg <= 1'b0;
        else
            lock_prev_reg <= lock_bit;
    end

    // a drop caused by leaving loop mode or entering stop is expected
    assign lol_ev = (unlock_s | (lock_prev_reg & ~lock_bit)) &
                    is_loop_mode(active_mode) & ~stop_mode;
    assign loc_ev = lost_s & clock_loss_detect_en;

    // sticky flags: a set in the clear cycle wins over the clear
    logic lock_lost_reg;
    logic clock_lost_reg;
    logic irqf_reg;
    logic armed_reg;
    logic new_irq;
    logic clear_ok;

    assign new_irq = (lol_ev & ~ctrl2_reg[C2_LOCK_RST_SEL]) |
                     (loc_ev & ~ctrl2_reg[C2_CLK_RST_SEL]);
    assign clear_ok = wr_s1 & avs_writedata[S1_IRQF] & armed_reg;

    always_ff @(posedge clk_sys) begin
        if (rst)
            lock_lost_reg <= 1'b0;
        else if (lol_ev)
            lock_lost_reg <= 1'b1;
        else if (clear_ok)
            lock_lost_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            clock_lost_reg <= 1'b0;
        else if (loc_ev)
            clock_lost_reg <= 1'b1;
        else if (clear_ok)
            clock_lost_reg <= 1'b0;
    end

    // a new request disarms the read so the clear must start over
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqf_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (new_irq) begin
            irqf_reg <= 1'b1;
            armed_reg <= 1'b0;
        end else if (clear_ok) begin
            irqf_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (rd_s1 && irqf_reg) begin
            armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clockgen_irq <= 1'b0;
            clockgen_reset_req <= 1'b0;
        end else begin
            clockgen_irq <= irqf_reg | new_irq;
            clockgen_reset_req <=
                (lock_lost_reg & ctrl2_reg[C2_LOCK_RST_SEL]) |
                (clock_lost_reg & ctrl2_reg[C2_CLK_RST_SEL]);
        end
    end

    // read data is loaded in the wait cycle and stands until the next read
    logic [7:0] stat1;

    assign stat1 = {active_mode, reference_kind, lock_lost_reg, lock_bit,
                    clock_lost_reg, ext_ready_s, irqf_reg};

    always_ff @(posedge clk_sys) begin
        if (rst)
            avs_readdata <= 32'h0;
        else if (avs_read && !ack_reg)
            avs_readdata <= {24'h0,
                reg_view(avs_address, ctrl1_reg, ctrl2_reg, stat1)};
    end
endmodule

//--- bench/cgc_ctrl_props.sv
// checker: bus answer, factor, mode and status relations of cgc_ctrl
`timescale 1ns/1ps
module cgc_ctrl_props
    import cgc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [cgc_pkg::CGC_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic clock_loss_detect_en,
    input wire logic [4:0] loop_factor_n,
    input wire logic [7:0] output_divide_r,
    input wire logic [1:0] active_mode,
    input wire logic reference_kind,
    input wire logic clockgen_irq
);
    logic wr1;
    logic wr_s;
    logic rd_s;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    assign wr1 = avs_write && !avs_waitrequest && avs_address == CGC_OFF_CTRL1;
    assign wr_s = avs_write && !avs_waitrequest && avs_address == CGC_OFF_STAT1;
    assign rd_s = avs_read && !avs_waitrequest && avs_address == CGC_OFF_STAT1;
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered");
    mult_code_a: assert property (loop_factor_n[0] == 1'b0
        && loop_factor_n >= 5'd4 && loop_factor_n <= 5'd18)
        else $error("multiplier outside table");
    div_code_a: assert property ($onehot(output_divide_r))
        else $error("divider not a power of two");
    detect_off_a: assert property (wr1 |-> ##2
        clock_loss_detect_en == !$past(avs_writedata[C1_DETECT_OFF], 2))
        else $error("detect enable does not follow control bit");
    mode_lag_a: assert property (wr1 |=> $stable(active_mode))
        else $error("mode changed in write cycle");
    mode_stat_a: assert property (rd_s |->
        avs_readdata[7:6] == $past(active_mode))
        else $error("mode status differs from active mode");
    ref_stat_a: assert property (rd_s |->
        avs_readdata[S1_REF_KIND] == $past(reference_kind))
        else $error("reference status wrong");
    lock_off_a: assert property (rd_s && !avs_readdata[S1_MODE_LO]
        |-> !avs_readdata[S1_LOCK]) else $error("lock set outside loop");
    zero_write_a: assert property (wr_s && !avs_writedata[S1_IRQF]
        && clockgen_irq |=> clockgen_irq) else $error("zero write cleared flag");
endmodule

bind cgc_ctrl cgc_ctrl_props chk (.clk_sys, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .clock_loss_detect_en, .loop_factor_n, .output_divide_r, .active_mode,
    .reference_kind, .clockgen_irq);

//--- bench/cgc_ctrl_tb_top.sv
// testbench: register accesses and pin events against cgc_ctrl
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module cgc_ctrl_tb_top;
    import cgc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic stop_mode = 1'b0;
    logic loop_enable = 1'b0;
    logic loop_locked_pin = 1'b0;
    logic loop_unlock_event_pin = 1'b0;
    logic clock_lost_pin = 1'b0;
    logic ext_ref_stable_pin = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, osc_enable, clock_loss_detect_en, reference_kind;
    logic clockgen_irq, clockgen_reset_req;
    logic [4:0] loop_factor_n;
    logic [7:0] output_divide_r;
    logic [1:0] active_mode;
    int fails = 0;
    int checks_done = 0;
    cgc_ctrl dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .stop_mode,
        .loop_enable, .loop_locked_pin, .loop_unlock_event_pin,
        .clock_lost_pin, .ext_ref_stable_pin, .osc_enable,
        .clock_loss_detect_en, .loop_factor_n, .output_divide_r,
        .active_mode, .reference_kind, .clockgen_irq, .clockgen_reset_req);
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // request held until waitrequest is seen low; no fixed latency assumed
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, e);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        `CHK(q & m, e);
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        wt(6);
        rst <= 1'b0;
        wt(1);
    endtask
    task automatic lose_clock;
        clock_lost_pin <= 1'b1;
        wt(4);
        clock_lost_pin <= 1'b0;
        wt(6);
    endtask
    initial begin
        wt(20000);
        fails++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        `CHK(loop_factor_n, 5'd4);
        `CHK(output_divide_r, 8'd1);
        rd(4'hc, 8'hff, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(CGC_OFF_CTRL2, {1'b0, i[2:0], 1'b0, 3'(7 - i)});
            wt(6);
            `CHK(loop_factor_n, 5'(4 + 2 * i));
            `CHK(output_divide_r, 8'h80 >> i);
        end
        rd(CGC_OFF_CTRL2, 8'hff, 8'h70);
        // second write lands inside the busy window and must be dropped
        wr(CGC_OFF_CTRL2, 8'h33);
        wr(CGC_OFF_CTRL2, 8'h55);
        wt(8);
        `CHK(loop_factor_n, 5'd10);
        `CHK(output_divide_r, 8'd8);
        wr(CGC_OFF_CTRL1, 8'h3c);
        wt(4);
        `CHK(active_mode, 2'b11);
        `CHK(reference_kind, 1'b1);
        loop_locked_pin <= 1'b1;
        wt(6);
        rd(CGC_OFF_STAT1, 8'he8, 8'he8);
        stop_mode <= 1'b1;
        wt(3);
        `CHK(osc_enable, 1'b1);
        wr(CGC_OFF_CTRL1, 8'h38);
        wt(3);
        `CHK(osc_enable, 1'b0);
        loop_enable <= 1'b1;
        wr(CGC_OFF_CTRL1, 8'h30);
        wt(3);
        `CHK(osc_enable, 1'b1);
        stop_mode <= 1'b0;
        wt(3);
        `CHK(active_mode, 2'b11);
        ext_ref_stable_pin <= 1'b1;
        wt(6);
        `CHK(active_mode, 2'b10);
        rd(CGC_OFF_STAT1, 8'hca, 8'h82);
        loop_locked_pin <= 1'b0;
        do_reset();
        `CHK(clockgen_irq, 1'b0);
        wr(CGC_OFF_CTRL1, 8'h02);
        wt(3);
        `CHK(clock_loss_detect_en, 1'b0);
        lose_clock();
        rd(CGC_OFF_STAT1, 8'h05, 8'h00);
        wr(CGC_OFF_CTRL1, 8'h00);
        wt(3);
        `CHK(clock_loss_detect_en, 1'b1);
        lose_clock();
        `CHK(clockgen_irq, 1'b1);
        rd(CGC_OFF_STAT1, 8'h05, 8'h05);
        wr(CGC_OFF_STAT1, 8'h00);
        wt(2);
        `CHK(clockgen_irq, 1'b1);
        lose_clock();
        wr(CGC_OFF_STAT1, 8'h01);
        wt(2);
        `CHK(clockgen_irq, 1'b1);
        rd(CGC_OFF_STAT1, 8'h01, 8'h01);
        wr(CGC_OFF_STAT1, 8'h01);
        wt(2);
        `CHK(clockgen_irq, 1'b0);
        rd(CGC_OFF_STAT1, 8'h05, 8'h00);
        wr(CGC_OFF_CTRL2, 8'h08);
        lose_clock();
        `CHK(clockgen_reset_req, 1'b1);
        `CHK(clockgen_irq, 1'b0);
        do_reset();
        wr(CGC_OFF_CTRL1, 8'h08);
        loop_unlock_event_pin <= 1'b1;
        wt(4);
        loop_unlock_event_pin <= 1'b0;
        wt(6);
        `CHK(clockgen_irq, 1'b1);
        rd(CGC_OFF_STAT1, 8'h10, 8'h10);
        wr(CGC_OFF_CTRL2, 8'h80);
        wt(3);
        `CHK(clockgen_reset_req, 1'b1);
        tally_and_finish();
    end
endmodule
